// ===== common/tcd_pkg.sv
// Purpose: constants for the transmit command word decoder
// Assumes: 32-bit command and data words, one clock
// Notes: field positions of command words A and B
//
// Behaviour
// - start offset from A[20:16], 0..31 bytes
// - A bit 13 marks first segment
// - A bit 12 marks last segment
// - size plus alignment gives padding words to drop
// - sum sizes, mismatch with length sets error
// - length differs from bytes supplied sets error
// - copy B tag to status word only
// - checksum when B14, first segment, engine enabled
// - B bit 13 suppresses appended check sequence
// - B bit 12 stops padding, forces check sequence
// - A bit 31 raises buffer done after load
// - command B equal across packet, else error
package tcd_pkg;
   localparam int unsigned TCD_W = 32;
   localparam int unsigned TCD_FIFO_DEPTH = 16;
   localparam int unsigned TCD_A_IOC = 31;
   localparam int unsigned TCD_A_ALIGN_HI = 25;
   localparam int unsigned TCD_A_ALIGN_LO = 24;
   localparam int unsigned TCD_A_OFS_HI = 20;
   localparam int unsigned TCD_A_OFS_LO = 16;
   localparam int unsigned TCD_A_FIRST = 13;
   localparam int unsigned TCD_A_LAST = 12;
   localparam int unsigned TCD_SIZE_HI = 10;
   localparam int unsigned TCD_B_TAG_HI = 31;
   localparam int unsigned TCD_B_TAG_LO = 16;
   localparam int unsigned TCD_B_CK = 14;
   localparam int unsigned TCD_B_NOCRC = 13;
   localparam int unsigned TCD_B_NOPAD = 12;
   localparam logic [1:0] TCD_AL_4 = 2'h0;
   localparam logic [1:0] TCD_AL_16 = 2'h1;
   localparam logic [1:0] TCD_AL_32 = 2'h2;
   localparam logic [12:0] TCD_ZERO13 = 13'h0000;
   localparam logic [13:0] TCD_ZERO14 = 14'h0000;
   localparam logic [13:0] TCD_ONE14 = 14'h0001;
   typedef enum logic [1:0] {
      TCD_S_CMDA = 2'b00,
      TCD_S_CMDB = 2'b01,
      TCD_S_DATA = 2'b11,
      TCD_S_PAD = 2'b10
   } tcd_state_e;
endpackage : tcd_pkg

// ===== logic/tcd_fifo.sv
// Purpose: synchronous FIFO holding transmit data words
// Assumes: single clock, valid/ready on both sides
// Notes: storage read data leaves through a register
`timescale 1ns/1ns
`default_nettype none
module tcd_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic [AW:0] count;
   logic out_valid_reg;
   logic [WIDTH-1:0] out_data_reg;
   logic do_wr;
   logic load_out;

   // ====================================================
   // flags; one extra word sits in the output register
   assign count = wr_ptr_reg - rd_ptr_reg;
   assign in_ready = (count != DEPTH[AW:0]);
   assign do_wr = in_valid && in_ready;
   assign load_out = (count != '0) && (!out_valid_reg || out_ready);
   assign out_valid = out_valid_reg;
   assign out_data = out_data_reg;

   // storage write, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (do_wr) begin
         mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (load_out) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

   // registered read data
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         out_valid_reg <= 1'b0;
         out_data_reg <= '0;
      end else if (load_out) begin
         out_valid_reg <= 1'b1;
         out_data_reg <= mem_reg[rd_ptr_reg[AW-1:0]];
      end else if (out_ready) begin
         out_valid_reg <= 1'b0;
      end
   end
endmodule : tcd_fifo
`default_nettype wire

// ===== logic/tcd_decoder.sv
// Purpose: decode per-buffer transmit command words A and B
// Assumes: host stream is cmd A, cmd B, data words, padding
// Notes: data words go through a 16-word FIFO to the MAC
`timescale 1ns/1ns
`default_nettype none
module tcd_decoder (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // host word stream
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [tcd_pkg::TCD_W-1:0] wr_data,
   // configuration
   input wire logic tx_checksum_engine_enable,
   // data toward the MAC
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [tcd_pkg::TCD_W-1:0] tx_data,
   // per-buffer decode, valid from command B on
   output logic [4:0] start_offset,
   output logic first_segment_flag,
   output logic last_segment_flag,
   output logic [15:0] status_tag,
   output logic tx_checksum_request,
   output logic add_fcs,
   output logic add_pad,
   // events
   output logic tx_buffer_done_flag,
   output logic transmitter_error_flag,
   output logic packet_end
);
   import tcd_pkg::*;

   tcd_state_e state_reg;
   logic [TCD_W-1:0] cmd_a_reg;
   logic [TCD_W-1:0] cmd_b_reg;
   logic [TCD_W-1:0] pkt_b_reg;
   logic [13:0] data_left_reg;
   logic [13:0] pad_left_reg;
   logic [11:0] total_reg;
   logic in_pkt_reg;
   logic mismatch_reg;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic take;
   logic a_first;
   logic a_last;
   logic [13:0] data_words;
   logic [13:0] pad_words;
   logic [11:0] total_next;

   // words spanned by offset plus size, rounded up to whole words
   function automatic logic [13:0] words_of(input logic [4:0] ofs,
                                            input logic [10:0] sz);
      logic [12:0] bytes;
      bytes = {8'h00, ofs} + {2'h0, sz} + 13'h0003;
      return {3'h0, bytes[12:2]};
   endfunction : words_of

   // extra words up to the end alignment; reserved code adds none
   function automatic logic [13:0] pad_of(input logic [13:0] w,
                                          input logic [1:0] al);
      logic [13:0] p;
      p = TCD_ZERO14;
      unique case (al)
         TCD_AL_16: p = {12'h000, 2'(-w[1:0])};
         TCD_AL_32: p = {11'h000, 3'(-w[2:0])};
         default: p = TCD_ZERO14;
      endcase
      return p;
   endfunction : pad_of

   // ====================================================
   // stream decode
   assign take = wr_valid && wr_ready;
   assign a_first = cmd_a_reg[TCD_A_FIRST];
   assign a_last = cmd_a_reg[TCD_A_LAST];
   assign data_words = words_of(
      cmd_a_reg[TCD_A_OFS_HI:TCD_A_OFS_LO],
      cmd_a_reg[TCD_SIZE_HI:0]);
   assign pad_words = pad_of(data_words,
      cmd_a_reg[TCD_A_ALIGN_HI:TCD_A_ALIGN_LO]);
   // only data words wait on the FIFO; commands and padding do not
   assign wr_ready = (state_reg != TCD_S_DATA) || fifo_in_ready;
   assign fifo_in_valid = wr_valid && (state_reg == TCD_S_DATA);
   // first segment restarts the running total
   assign total_next = (a_first ? 12'h000 : total_reg)
      + {1'b0, cmd_a_reg[TCD_SIZE_HI:0]};

   // sequencing through commands, data and padding
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= TCD_S_CMDA;
         data_left_reg <= TCD_ZERO14;
         pad_left_reg <= TCD_ZERO14;
      end else if (take) begin
         unique case (state_reg)
            TCD_S_CMDA: state_reg <= TCD_S_CMDB;
            TCD_S_CMDB: begin
               data_left_reg <= data_words;
               pad_left_reg <= pad_words;
               state_reg <= (data_words != TCD_ZERO14) ? TCD_S_DATA :
                  (pad_words != TCD_ZERO14) ? TCD_S_PAD : TCD_S_CMDA;
            end
            TCD_S_DATA: begin
               data_left_reg <= data_left_reg - TCD_ONE14;
               if (data_left_reg == TCD_ONE14) begin
                  state_reg <= (pad_left_reg != TCD_ZERO14) ?
                     TCD_S_PAD : TCD_S_CMDA;
               end
            end
            TCD_S_PAD: begin
               // discarded, never reaches the FIFO
               pad_left_reg <= pad_left_reg - TCD_ONE14;
               if (pad_left_reg == TCD_ONE14) begin
                  state_reg <= TCD_S_CMDA;
               end
            end
         endcase
      end
   end

   // command capture
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cmd_a_reg <= '0;
         cmd_b_reg <= '0;
      end else if (take && state_reg == TCD_S_CMDA) begin
         cmd_a_reg <= wr_data;
      end else if (take && state_reg == TCD_S_CMDB) begin
         cmd_b_reg <= wr_data;
      end
   end

   // packet tracking: running total, command B consistency
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         total_reg <= 12'h000;
         pkt_b_reg <= '0;
         in_pkt_reg <= 1'b0;
         mismatch_reg <= 1'b0;
      end else if (take && state_reg == TCD_S_CMDB) begin
         total_reg <= total_next;
         in_pkt_reg <= !a_last;
         if (a_first) begin
            pkt_b_reg <= wr_data;
            mismatch_reg <= 1'b0;
         end else if (wr_data != pkt_b_reg || !in_pkt_reg) begin
            mismatch_reg <= 1'b1;
         end
      end
   end

   // error and end events at command B, done at the last data word (or command B with no data); one cycle each
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         transmitter_error_flag <= 1'b0;
         tx_buffer_done_flag <= 1'b0;
         packet_end <= 1'b0;
      end else begin
         transmitter_error_flag <= 1'b0;
         packet_end <= 1'b0;
         tx_buffer_done_flag <= 1'b0;
         if (take && state_reg == TCD_S_CMDB && a_last) begin
            packet_end <= 1'b1;
            // total against length, plus any command B disagreement;
            // a first segment starts clean, so a stale mismatch or an
            // earlier packet's command B must not count against it
            transmitter_error_flag <= (total_next !=
               {1'b0, wr_data[TCD_SIZE_HI:0]})
               || (!a_first && (mismatch_reg
               || !in_pkt_reg || wr_data != pkt_b_reg));
         end
         // buffer done once its last data word is loaded
         if (cmd_a_reg[TCD_A_IOC] && take &&
             ((state_reg == TCD_S_DATA && data_left_reg == TCD_ONE14) ||
              (state_reg == TCD_S_CMDB && data_words == TCD_ZERO14))) begin
            tx_buffer_done_flag <= 1'b1;
         end
      end
   end

   // decoded per-buffer controls
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         start_offset <= 5'h00;
         first_segment_flag <= 1'b0;
         last_segment_flag <= 1'b0;
         status_tag <= 16'h0000;
         tx_checksum_request <= 1'b0;
         add_fcs <= 1'b0;
         add_pad <= 1'b0;
      end else if (take && state_reg == TCD_S_CMDB) begin
         start_offset <= cmd_a_reg[TCD_A_OFS_HI:TCD_A_OFS_LO];
         first_segment_flag <= a_first;
         last_segment_flag <= a_last;
         status_tag <= wr_data[TCD_B_TAG_HI:TCD_B_TAG_LO];
         tx_checksum_request <= wr_data[TCD_B_CK] && a_first
            && tx_checksum_engine_enable;
         // no-pad forces the check sequence back on
         add_fcs <= !wr_data[TCD_B_NOCRC]
            || wr_data[TCD_B_NOPAD];
         add_pad <= !wr_data[TCD_B_NOPAD];
      end
   end

   // data buffer toward the MAC; back-pressure reaches wr_ready
   tcd_fifo #(
      .WIDTH(TCD_W),
      .DEPTH(TCD_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(wr_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );
endmodule : tcd_decoder
`default_nettype wire

// ===== bench/tcd_decoder_assertions.sv
// Purpose: port checks for the transmit command decoder
// Assumes: one clock, asynchronous low reset
// Notes: bound to every decoder instance below
`timescale 1ns/1ns
`default_nettype none
module tcd_decoder_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // watched ports
   input wire logic wr_ready,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [tcd_pkg::TCD_W-1:0] tx_data,
   input wire logic first_segment_flag,
   input wire logic tx_checksum_request,
   input wire logic add_fcs,
   input wire logic add_pad,
   input wire logic tx_buffer_done_flag,
   input wire logic transmitter_error_flag,
   input wire logic packet_end
);
   import tcd_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   // ====
   // decode events
   chk_err_at_end:
      assert property (transmitter_error_flag |-> packet_end)
      else $error("error flag outside packet end");
   chk_end_single:
      assert property (packet_end |=> !packet_end)
      else $error("packet end longer than one cycle");
   chk_sum_first:
      assert property (tx_checksum_request |-> first_segment_flag)
      else $error("checksum request without first segment");
   chk_fcs_nopad:
      assert property (packet_end && !add_pad |-> add_fcs)
      else $error("check sequence dropped with padding off");
   chk_done_single:
      assert property (tx_buffer_done_flag |=> !tx_buffer_done_flag)
      else $error("buffer done longer than one cycle");
   // ====
   // stream handshake; refusal only while words wait
   chk_refuse_full:
      assert property (!wr_ready |-> tx_valid)
      else $error("host refused with nothing queued");
   chk_tx_hold:
      assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("outgoing word changed while stalled");
   chk_reset_idle:
      assert property ($rose(arst_n) |-> wr_ready && !tx_valid && !packet_end)
      else $error("not idle after reset");
endmodule : tcd_decoder_chk
bind tcd_decoder tcd_decoder_chk u_chk (.clk_sys, .arst_n, .wr_ready,
   .tx_valid, .tx_ready, .tx_data, .first_segment_flag,
   .tx_checksum_request, .add_fcs, .add_pad, .tx_buffer_done_flag,
   .transmitter_error_flag, .packet_end);
`default_nettype wire

// ===== bench/tcd_host_model.sv
// Purpose: host feeding command words, data and padding
// Assumes: offsets below one word, so no whole offset words
// Notes: slow leaves an idle cycle after each taken word
`timescale 1ns/1ns
`default_nettype none
module tcd_host_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // word stream
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [tcd_pkg::TCD_W-1:0] wr_data,
   // pacing
   input wire logic slow
);
   import tcd_pkg::*;
   logic [TCD_W-1:0] q[$], dq[$];
   logic nv;
   int seq = 0;
   // ====
   // one buffer; fl is {checksum, no check sequence, no pad}
   task automatic send(input logic ioc, fs, ls, input logic [1:0] al,
         input logic [4:0] ofs, input logic [10:0] sz, ln,
         input logic [15:0] tag, input logic [2:0] fl);
      int nw, np;
      nw = (ofs + sz + 3) / 4;
      np = al == TCD_AL_16 ? (4 - nw % 4) % 4 : 0;
      np = al == TCD_AL_32 ? (8 - nw % 8) % 8 : np;
      q.push_back({ioc, 5'h0, al, 3'h0, ofs, 2'h0, fs, ls,
         1'b0, sz});
      q.push_back({tag, 1'b0, fl, 1'b0, ln});
      for (int i = 0; i < nw; i++) begin
         q.push_back({16'hDA7A, seq[15:0]});
         dq.push_back({16'hDA7A, seq[15:0]});
         seq++;
      end
      for (int i = 0; i < np; i++) begin
         q.push_back(32'hFFFFFFFF);
      end
   endtask : send
   // word held until taken; idle bus shows the inverse, not stale data
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_valid <= 1'b0;
         wr_data <= 32'h00000000;
      end else begin
         if (wr_valid && wr_ready) begin
            q.delete(0);
         end
         nv = q.size() != 0 && !(slow && wr_valid && wr_ready);
         wr_valid <= nv;
         wr_data <= nv ? q[0] : ~wr_data;
      end
   end
endmodule : tcd_host_model
`default_nettype wire

// ===== bench/tcd_decoder_bench.sv
// Purpose: self-checking bench for the command decoder
// Assumes: host model drives the word stream
// Notes: every word leaving toward the MAC is compared
`timescale 1ns/1ns
`default_nettype none
module tcd_decoder_bench;
   import tcd_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic tx_checksum_engine_enable = 1'b0;
   logic tx_ready = 1'b1;
   logic slow = 1'b0;
   logic wr_valid, wr_ready, tx_valid, first_segment_flag;
   logic last_segment_flag, tx_checksum_request, add_fcs, add_pad;
   logic tx_buffer_done_flag, transmitter_error_flag, packet_end;
   logic [TCD_W-1:0] wr_data, tx_data;
   logic [4:0] start_offset;
   logic [15:0] status_tag;
   int num_errors = 0;
   int n_tests = 0;
   bit hung = 1'b0;
   int ends = 0, dones = 0, errs = 0, e0, d0, x0;
   // ====
   // clock, design, host
   always #25 clk_sys = ~clk_sys;
   tcd_decoder dut (.clk_sys, .arst_n, .wr_valid, .wr_ready, .wr_data,
      .tx_checksum_engine_enable, .tx_valid, .tx_ready, .tx_data,
      .start_offset, .first_segment_flag, .last_segment_flag, .status_tag,
      .tx_checksum_request, .add_fcs, .add_pad, .tx_buffer_done_flag,
      .transmitter_error_flag, .packet_end);
   tcd_host_model host (.clk_sys, .arst_n, .wr_valid, .wr_ready, .wr_data,
      .slow);
   task automatic chk(input string nm, input logic [31:0] ex, got);
      n_tests++;
      if (got !== ex) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   // event tally; pad words must never reach the MAC side
   always @(posedge clk_sys) begin
      ends <= ends + int'(packet_end === 1'b1);
      dones <= dones + int'(tx_buffer_done_flag === 1'b1);
      errs <= errs + int'(transmitter_error_flag === 1'b1);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         chk("tx_data", host.dq.pop_front(), tx_data);
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   // ====
   // shared steps
   task automatic mark();
      e0 = ends;
      d0 = dones;
      x0 = errs;
   endtask : mark
   task automatic settle(input string nm, input int ne, nd, nx);
      int k;
      k = 0;
      while (k < 3000 && (ends < e0 + ne || host.q.size() != 0
            || host.dq.size() != 0)) begin
         @(posedge clk_sys);
         k++;
      end
      // a hang counts once; later scenarios are skipped
      if (k == 3000) begin
         num_errors++;
         hung = 1'b1;
      end
      repeat (2) @(posedge clk_sys);
      chk("events", {8'(ne), 8'(nd), 8'(nx)},
         {8'(ends - e0), 8'(dones - d0), 8'(errs - x0)});
      $display("%s finished", nm);
   endtask : settle
   task automatic dec(input logic [4:0] o, input logic f, l,
         input logic [15:0] t, input logic c, fc, pd);
      chk("decode", {6'h0, o, f, l, t, c, fc, pd}, {6'h0, start_offset,
         first_segment_flag, last_segment_flag, status_tag,
         tx_checksum_request, add_fcs, add_pad});
   endtask : dec
   // ====
   // scenarios
   task automatic t_single();
      tx_checksum_engine_enable <= 1'b1;
      mark();
      host.send(1, 1, 1, TCD_AL_16, 5'h03, 11'h00E, 11'h00E, 16'hA5C3, 3'h6);
      settle("single", 1, 1, 0);
      dec(5'h03, 1, 1, 16'hA5C3, 1, 0, 1);
   endtask : t_single
   task automatic t_multi();
      slow <= 1'b1;
      mark();
      host.send(0, 1, 0, TCD_AL_32, 5'h01, 11'h005, 11'h010, 16'h0F1E, 3'h7);
      host.send(1, 0, 0, TCD_AL_32, 5'h00, 11'h004, 11'h010, 16'h0F1E, 3'h7);
      host.send(0, 0, 1, TCD_AL_32, 5'h02, 11'h007, 11'h010, 16'h0F1E, 3'h7);
      settle("multi", 1, 1, 0);
      dec(5'h02, 0, 1, 16'h0F1E, 0, 1, 0);
      slow <= 1'b0;
   endtask : t_multi
   task automatic t_errors();
      tx_checksum_engine_enable <= 1'b0;
      mark();
      host.send(0, 1, 1, TCD_AL_4, 5'h00, 11'h009, 11'h008, 16'h1111, 3'h0);
      host.send(0, 1, 0, TCD_AL_4, 5'h00, 11'h004, 11'h008, 16'h2222, 3'h0);
      host.send(0, 0, 1, TCD_AL_4, 5'h00, 11'h004, 11'h008, 16'h3333, 3'h0);
      // last segment with no packet open; leaves a stale mismatch
      host.send(0, 0, 1, TCD_AL_4, 5'h00, 11'h004, 11'h004, 16'h5555, 3'h0);
      host.send(1, 1, 1, TCD_AL_4, 5'h00, 11'h000, 11'h000, 16'h4444, 3'h4);
      settle("errors", 4, 1, 3);
      dec(5'h00, 1, 1, 16'h4444, 0, 1, 1);
   endtask : t_errors
   task automatic t_full();
      tx_ready <= 1'b0;
      mark();
      host.send(1, 1, 1, TCD_AL_4, 5'h00, 11'h050, 11'h050, 16'h5A5A, 3'h0);
      for (int k = 0; k < 200 && wr_ready !== 1'b0; k++) begin
         @(posedge clk_sys);
      end
      chk("wr_ready", 32'h0, {31'h0, wr_ready});
      repeat (4) @(posedge clk_sys);
      tx_ready <= 1'b1;
      settle("full", 1, 1, 0);
   endtask : t_full
   initial begin
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      t_single();
      if (!hung) begin
         t_multi();
      end
      if (!hung) begin
         t_errors();
      end
      if (!hung) begin
         t_full();
      end
      results();
   end
endmodule : tcd_decoder_bench
`default_nettype wire
